// ==== pic_cfg.svh ====
// Register offsets, field positions, vector base and trap level of the interrupt controller
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH
`define PIC_OFF_CTRL1 12'h000
`define PIC_OFF_CTRL2 12'h004
`define PIC_OFF_CTRL3 12'h008
`define PIC_OFF_CTRL4 12'h00C
`define PIC_OFF_VSTAT 12'h010
`define PIC_OFF_PSTAT 12'h014
`define PIC_OFF_CORE 12'h018
`define PIC_OFF_FLAG 12'h020
`define PIC_OFF_ENAB 12'h024
`define PIC_OFF_PRIO0 12'h028
`define PIC_OFF_PRIO1 12'h02C
`define PIC_OFF_ISTAT 12'h030
`define PIC_OFF_IMASK 12'h034
`define PIC_OFF_ACK 12'h038
`define PIC_BIT_NESTING_DISABLE 15
`define PIC_BIT_GIE 15
`define PIC_BIT_SOFT_HARD_TRAP_FLAG 0
`define PIC_BIT_TOP 3
`define PIC_PSTAT_LO 5
`define PIC_PSTAT_HI 7
`define PIC_VEC_BASE 8'h08
`define PIC_TRAP_LVL 4'h8
`define PIC_ZERO32 32'h00000000
`endif

// ==== pic_pkg.sv ====
// Types shared by the interrupt controller files
package pic_pkg;
  typedef logic [31:0] pic_word_t;
  typedef logic [2:0] pic_prio_t;
  typedef logic [3:0] pic_level_t;
  typedef logic [7:0] pic_vec_t;
endpackage

// ==== pic_arbiter.sv ====
// Priority arbiter choosing the winning request among enabled flagged sources
`timescale 1ns/10ps
`include "pic_cfg.svh"
module pic_arbiter #(
  parameter int NSRC = 16
) (
  input wire logic [NSRC-1:0] req,
  input wire logic [3*NSRC-1:0] prio,
  input wire pic_pkg::pic_level_t cur_level,
  output logic found,
  output pic_pkg::pic_vec_t vec,
  output pic_pkg::pic_prio_t level
);
  import pic_pkg::*;
  // Highest priority wins; scan downwards so lower index wins a tie
  always_comb begin
    found = 1'b0;
    vec = 8'h00;
    level = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i] && ({1'b0, prio[3*i +: 3]} > cur_level) &&
          (!found || prio[3*i +: 3] >= level)) begin // RULE_15
        found = 1'b1;
        level = prio[3*i +: 3];
        vec = 8'(`PIC_VEC_BASE + i); // RULE_11
      end
    end
  end
endmodule

// ==== pic_top.sv ====
// Vectored prioritized interrupt controller with APB register access
// Functional notes
// RULE_01: Control register one holds nesting disable and trap status flags.
// RULE_02: Control register two sets external edge polarity and global enable.
// RULE_03: Control register three holds DMA and loop-stack overflow trap flags.
// RULE_04: Control register four holds the software hard trap flag.
// RULE_05: Each source has a flag set by hardware, cleared only by software.
// RULE_06: A source with its enable clear never raises a request.
// RULE_07: Each source has a writable three-bit priority field, eight levels.
// RULE_08: Taken interrupt latches 8-bit vector and 4-bit new level.
// RULE_09: Latched level equals priority of the serviced pending interrupt.
// RULE_10: Flag, enable, priority fields packed in ascending vector order.
// RULE_11: External request zero is vector 8, bit 0, priority bits 2..0.
// RULE_12: Lower three level bits at status bits 7..5, readable and writable.
// RULE_13: Top level bit in core register is read-only to software.
// RULE_14: With nesting disabled the three lower level bits are read-only.
// RULE_15: Request only above current level; highest wins, lower vector ties.
`timescale 1ns/10ps
`include "pic_cfg.svh"
module pic_top #(
  parameter int NSRC = 16,
  parameter int NEXT = 3,
  parameter int NTRAP = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire pic_pkg::pic_word_t pwdata,
  output pic_pkg::pic_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NSRC-1:0] periph_req,
  input wire logic [NEXT-1:0] ext_pin,
  input wire logic [NTRAP-1:0] trap_evt,
  input wire logic dma_trap_evt,
  input wire logic loop_ovf_evt,
  input wire logic irq_taken,
  input wire logic trap_taken,
  input wire logic trap_return,
  output logic irq_req,
  output pic_pkg::pic_vec_t irq_vec,
  output pic_pkg::pic_level_t irq_level,
  output logic trap_req,
  output logic irq
);
  import pic_pkg::*;

  logic [NSRC-1:0] flag_ff;
  logic [NSRC-1:0] enab_ff;
  logic [3*NSRC-1:0] prio_ff;
  logic nesting_disable_ff;
  logic [NTRAP-1:0] trap_ff;
  logic gie_ff;
  logic [NEXT-1:0] edge_pol_ff;
  logic dma_trap_ff;
  logic loop_ovf_ff;
  logic soft_hard_trap_flag_ff;
  pic_vec_t vnum_ff;
  pic_level_t vlvl_ff;
  logic [2:0] ipl_lo_ff;
  logic ipl_top_ff;
  logic [3:0] istat_ff;
  logic [3:0] imask_ff;
  logic [NEXT-1:0] ext_s1_ff;
  logic [NEXT-1:0] ext_s2_ff;
  logic [NEXT-1:0] ext_s3_ff;
  logic [NSRC-1:0] hw_set;
  logic [NSRC-1:0] req_vec;
  logic wr_en;
  logic rd_en;
  logic arb_found;
  pic_vec_t arb_vec;
  pic_prio_t arb_lvl;
  pic_level_t cur_level;
  logic [3:0] evt;
  logic take;

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign cur_level = {ipl_top_ff, ipl_lo_ff};

  // Pin synchronisers, third stage only for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_ff <= '0;
      ext_s2_ff <= '0;
      ext_s3_ff <= '0;
    end else begin
      ext_s1_ff <= ext_pin;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
    end
  end

  // Hardware set terms: externals first, selected edge per pin
  always_comb begin
    hw_set = periph_req;
    for (int i = 0; i < NEXT; i++) begin
      hw_set[i] = edge_pol_ff[i] ? (ext_s3_ff[i] && !ext_s2_ff[i])
                                 : (ext_s2_ff[i] && !ext_s3_ff[i]); // RULE_02
    end
  end

  // Per-source flag, enable and priority storage
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag_ff[g] <= 1'b0;
        end else if (hw_set[g]) begin
          flag_ff[g] <= 1'b1; // RULE_05
        end else if (wr_en && paddr == `PIC_OFF_FLAG) begin
          flag_ff[g] <= pwdata[g]; // RULE_05 RULE_10
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          enab_ff[g] <= 1'b0;
        end else if (wr_en && paddr == `PIC_OFF_ENAB) begin
          enab_ff[g] <= pwdata[g]; // RULE_10
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prio_ff[3*g +: 3] <= 3'h0;
        end else if (wr_en && paddr == ((g < 8) ? `PIC_OFF_PRIO0 : `PIC_OFF_PRIO1)) begin
          prio_ff[3*g +: 3] <= pwdata[4*(g%8) +: 3]; // RULE_07 RULE_10 RULE_11
        end
      end
      assign req_vec[g] = flag_ff[g] && enab_ff[g] && gie_ff; // RULE_06 RULE_02
    end
  endgenerate

  // Control register one: nesting disable and trap flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nesting_disable_ff <= 1'b0;
      trap_ff <= '0;
    end else begin
      if (wr_en && paddr == `PIC_OFF_CTRL1) begin
        nesting_disable_ff <= pwdata[`PIC_BIT_NESTING_DISABLE]; // RULE_01
      end
      for (int i = 0; i < NTRAP; i++) begin
        if (trap_evt[i]) begin
          trap_ff[i] <= 1'b1; // RULE_01
        end else if (wr_en && paddr == `PIC_OFF_CTRL1) begin
          trap_ff[i] <= pwdata[i];
        end
      end
    end
  end

  // Control register two: global enable and external polarity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_ff <= 1'b1;
      edge_pol_ff <= '0;
    end else if (wr_en && paddr == `PIC_OFF_CTRL2) begin
      gie_ff <= pwdata[`PIC_BIT_GIE]; // RULE_02
      edge_pol_ff <= pwdata[NEXT-1:0]; // RULE_02
    end
  end

  // Control registers three and four: DMA, loop and soft trap flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_trap_ff <= 1'b0;
      loop_ovf_ff <= 1'b0;
      soft_hard_trap_flag_ff <= 1'b0;
    end else begin
      if (dma_trap_evt) begin
        dma_trap_ff <= 1'b1; // RULE_03
      end else if (wr_en && paddr == `PIC_OFF_CTRL3) begin
        dma_trap_ff <= pwdata[0];
      end
      if (loop_ovf_evt) begin
        loop_ovf_ff <= 1'b1; // RULE_03
      end else if (wr_en && paddr == `PIC_OFF_CTRL3) begin
        loop_ovf_ff <= pwdata[1];
      end
      if (wr_en && paddr == `PIC_OFF_CTRL4) begin
        soft_hard_trap_flag_ff <= pwdata[`PIC_BIT_SOFT_HARD_TRAP_FLAG]; // RULE_04
      end
    end
  end

  pic_arbiter #(
    .NSRC(NSRC)
  ) u_arb (
    .req(req_vec),
    .prio(prio_ff),
    .cur_level(cur_level),
    .found(arb_found),
    .vec(arb_vec),
    .level(arb_lvl)
  );

  assign irq_req = arb_found; // RULE_15
  assign irq_vec = arb_vec;
  assign irq_level = {1'b0, arb_lvl};
  assign trap_req = (|trap_ff) || dma_trap_ff || loop_ovf_ff || soft_hard_trap_flag_ff;
  assign take = irq_taken && arb_found;

  // Vector status latch on interrupt acceptance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vnum_ff <= 8'h00;
      vlvl_ff <= 4'h0;
    end else if (take) begin
      vnum_ff <= arb_vec; // RULE_08
      vlvl_ff <= {1'b0, arb_lvl}; // RULE_08 RULE_09
    end
  end

  // Processor level: lower bits software writable unless nesting disabled, top bit hardware only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ipl_lo_ff <= 3'h0;
      ipl_top_ff <= 1'b0;
    end else begin
      if (trap_taken) begin
        ipl_top_ff <= 1'b1; // RULE_13
      end else if (trap_return) begin
        ipl_top_ff <= 1'b0;
      end
      if (take && !nesting_disable_ff) begin
        ipl_lo_ff <= arb_lvl;
      end else if (take && nesting_disable_ff) begin
        ipl_lo_ff <= 3'h7;
      end else if (wr_en && paddr == `PIC_OFF_PSTAT && !nesting_disable_ff) begin
        ipl_lo_ff <= pwdata[`PIC_PSTAT_HI:`PIC_PSTAT_LO]; // RULE_12 RULE_14
      end
    end
  end

  // Interrupt status events: request, trap, take, soft trap
  assign evt = {soft_hard_trap_flag_ff, take, trap_req, arb_found};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_ff <= 4'h0;
    end else if (wr_en && paddr == `PIC_OFF_ISTAT) begin
      istat_ff <= (istat_ff & ~pwdata[3:0]) | evt;
    end else begin
      istat_ff <= istat_ff | evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_ff <= 4'h0;
    end else if (wr_en && paddr == `PIC_OFF_IMASK) begin
      imask_ff <= pwdata[3:0];
    end
  end

  assign irq = |(istat_ff & imask_ff);

  // Error for unmapped addresses
  always_comb begin
    unique case (paddr)
      `PIC_OFF_CTRL1, `PIC_OFF_CTRL2, `PIC_OFF_CTRL3, `PIC_OFF_CTRL4,
      `PIC_OFF_VSTAT, `PIC_OFF_PSTAT, `PIC_OFF_CORE, `PIC_OFF_FLAG,
      `PIC_OFF_ENAB, `PIC_OFF_PRIO0, `PIC_OFF_PRIO1, `PIC_OFF_ISTAT,
      `PIC_OFF_IMASK: pslverr = 1'b0;
      default: pslverr = psel && penable;
    endcase
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `PIC_ZERO32;
    end else if (psel && !penable && !pwrite) begin
      prdata <= `PIC_ZERO32;
      unique case (paddr)
        `PIC_OFF_CTRL1: prdata <= 32'({nesting_disable_ff, 15'h0000}) | 32'(trap_ff);
        `PIC_OFF_CTRL2: prdata <= 32'({gie_ff, 15'h0000}) | 32'(edge_pol_ff);
        `PIC_OFF_CTRL3: prdata <= {30'h00000000, loop_ovf_ff, dma_trap_ff};
        `PIC_OFF_CTRL4: prdata <= {31'h00000000, soft_hard_trap_flag_ff};
        `PIC_OFF_VSTAT: prdata <= {20'h00000, vlvl_ff, vnum_ff};
        `PIC_OFF_PSTAT: prdata <= {24'h000000, ipl_lo_ff, 5'h00}; // RULE_12
        `PIC_OFF_CORE: prdata <= 32'(ipl_top_ff) << `PIC_BIT_TOP; // RULE_13
        `PIC_OFF_FLAG: prdata <= 32'(flag_ff);
        `PIC_OFF_ENAB: prdata <= 32'(enab_ff);
        `PIC_OFF_PRIO0: prdata <= pack_prio(0);
        `PIC_OFF_PRIO1: prdata <= pack_prio(8);
        `PIC_OFF_ISTAT: prdata <= {28'h0000000, istat_ff};
        `PIC_OFF_IMASK: prdata <= {28'h0000000, imask_ff};
        default: prdata <= `PIC_ZERO32;
      endcase
    end
  end

  // Packs eight three-bit priority fields into nibble lanes
  function automatic pic_word_t pack_prio(input int base);
    pic_word_t w;
    w = `PIC_ZERO32;
    for (int k = 0; k < 8; k++) begin
      if (base + k < NSRC) begin
        w[4*k +: 3] = prio_ff[3*(base+k) +: 3];
      end
    end
    return w;
  endfunction
endmodule

// ==== pic_top_monitor.sv ====
// Port checker for the interrupt controller
`timescale 1ns/10ps
module pic_top_monitor #(
  parameter int NSRC = 16,
  parameter int NTRAP = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [NTRAP-1:0] trap_evt,
  input wire logic dma_trap_evt,
  input wire logic irq_taken,
  input wire logic trap_taken,
  input wire logic irq_req,
  input wire pic_pkg::pic_vec_t irq_vec,
  input wire pic_pkg::pic_level_t irq_level,
  input wire logic trap_req
);
  import pic_pkg::*;
  // Any completed register write
  wire logic wr = psel && penable && pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Trap flags: set by events, kept until software writes
  AST_TRAP_SET: assert property (|trap_evt |=> trap_req)
    else $error("trap event lost");
  AST_DMA_SET: assert property (dma_trap_evt |=> trap_req)
    else $error("dma trap lost");
  AST_TRAP_HOLD: assert property (trap_req && !wr |=> trap_req)
    else $error("trap flag cleared by hardware");
  // Pending request survives until taken or rewritten
  AST_REQ_HOLD: assert property (irq_req && !wr && !irq_taken && !trap_taken |=> irq_req)
    else $error("request dropped");
  // Vector and level shape of a presented request
  AST_VEC_RANGE: assert property (irq_req |-> irq_vec >= 8'h08 && irq_vec < 8'h08 + NSRC)
    else $error("vector out of range");
  AST_LVL_FORM: assert property (irq_req |-> !irq_level[3] && irq_level != 4'h0)
    else $error("bad request level");
  // Taking raises the level to at least the winner's priority
  AST_TAKE_DROP: assert property (irq_taken && !wr |=> !irq_req)
    else $error("request after take");
  AST_TOP_BLOCK: assert property (trap_taken |=> !irq_req [*2])
    else $error("user request inside trap");
endmodule
bind pic_top pic_top_monitor #(.NSRC(NSRC), .NTRAP(NTRAP)) i_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .trap_evt(trap_evt), .dma_trap_evt(dma_trap_evt), .irq_taken(irq_taken),
  .trap_taken(trap_taken), .irq_req(irq_req), .irq_vec(irq_vec),
  .irq_level(irq_level), .trap_req(trap_req)
);

// ==== pic_core_model.sv ====
// Behavioural core taking vectored interrupts and traps
`timescale 1ns/10ps
module pic_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic [3:0] dly,
  input wire logic irq_req,
  input wire logic trap_req,
  output logic irq_taken,
  output logic trap_taken,
  output logic trap_return
);
  logic [3:0] cnt_ff;
  logic trap_ff;
  // Accept after dly cycles, traps first; return once trap flags clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 4'h0;
      trap_ff <= 1'b0;
      irq_taken <= 1'b0;
      trap_taken <= 1'b0;
      trap_return <= 1'b0;
    end else begin
      irq_taken <= 1'b0;
      trap_taken <= 1'b0;
      trap_return <= trap_ff && !trap_req;
      if (trap_ff && !trap_req) begin
        trap_ff <= 1'b0;
      end
      if (!en || irq_taken || trap_taken || !(irq_req || trap_req && !trap_ff)) begin
        cnt_ff <= 4'h0;
      end else if (cnt_ff != dly) begin
        cnt_ff <= cnt_ff + 4'h1;
      end else if (trap_req && !trap_ff) begin
        trap_taken <= 1'b1;
        trap_ff <= 1'b1;
      end else begin
        irq_taken <= 1'b1;
      end
    end
  end
endmodule

// ==== prioritized_interrupt_control_tb.sv ====
// Self-checking bench of the interrupt controller
`timescale 1ns/10ps
`include "pic_cfg.svh"
module prioritized_interrupt_control_tb;
  import pic_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic dma = 1'b0, lovf = 1'b0, en = 1'b0, err, pready, pslverr;
  logic irq_req, trap_req, irq, itk, ttk, trt;
  logic [11:0] paddr = 12'h000;
  logic [15:0] preq = 16'h0000;
  logic [2:0] pin = 3'h0;
  logic [7:0] tev = 8'h00;
  logic [3:0] dly = 4'h0, s, p;
  pic_word_t pwdata = 32'h0, prdata, rd;
  pic_vec_t vec;
  pic_level_t lvl;
  int fails = 0, n_tests = 0, k;
  // Rows: source, priority, expected vector
  logic [15:0] rows [4] = '{16'h310B, 16'h770F, 16'hF417, 16'hA212};
  pic_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_req(preq), .ext_pin(pin), .trap_evt(tev), .dma_trap_evt(dma),
    .loop_ovf_evt(lovf), .irq_taken(itk), .trap_taken(ttk), .trap_return(trt),
    .irq_req(irq_req), .irq_vec(vec), .irq_level(lvl), .trap_req(trap_req), .irq(irq)
  );
  pic_core_model i_core (
    .pclk(pclk), .presetn(presetn), .en(en), .dly(dly), .irq_req(irq_req),
    .trap_req(trap_req), .irq_taken(itk), .trap_taken(ttk), .trap_return(trt)
  );
  task automatic complete_run();
    if (fails == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input pic_word_t g, input pic_word_t e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One APB transfer, settled outputs on return
  task automatic apb(input logic w, input logic [11:0] a, input pic_word_t d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the slave; only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic rc(input logic [11:0] a, input pic_word_t e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic pulse(input logic [15:0] m);
    @(posedge pclk);
    preq <= m;
    @(posedge pclk);
    preq <= 16'h0000;
    @(negedge pclk);
  endtask
  initial begin
    forever #50 pclk = ~pclk;
  end
  // Watchdog
  initial begin
    #2000000;
    fails++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rc(`PIC_OFF_CTRL2, 32'h8000);
    rc(`PIC_OFF_VSTAT, 32'h0);
    foreach (rows[i]) begin
      s = rows[i][15:12];
      p = rows[i][11:8];
      apb(1'b1, s[3] ? `PIC_OFF_PRIO1 : `PIC_OFF_PRIO0, 32'(p) << (4 * s[2:0]));
      pulse(16'h0001 << s);
      chk(32'(irq_req), 32'h0);
      apb(1'b1, `PIC_OFF_ENAB, 32'h1 << s);
      chk({19'h0, irq_req, vec, lvl}, {19'h0, 1'b1, rows[i][7:0], p});
      @(posedge pclk);
      dly <= 4'(3 * i);
      en <= 1'b1;
      for (k = 0; k < 40 && itk !== 1'b1; k++)
        @(posedge pclk);
      en <= 1'b0;
      chk(32'(itk), 32'h1);
      rc(`PIC_OFF_VSTAT, {20'h0, p, rows[i][7:0]});
      rc(`PIC_OFF_PSTAT, 32'(p) << 5);
      chk(32'(irq_req), 32'h0);
      rc(`PIC_OFF_FLAG, 32'h1 << s);
      apb(1'b1, `PIC_OFF_FLAG, 32'h0);
      apb(1'b1, `PIC_OFF_PSTAT, 32'h0);
    end
    // Tie on equal priority, then level threshold
    apb(1'b1, `PIC_OFF_PRIO0, 32'h330000);
    apb(1'b1, `PIC_OFF_ENAB, 32'h30);
    pulse(16'h0030);
    chk({19'h0, irq_req, vec, lvl}, 32'h10C3);
    apb(1'b1, `PIC_OFF_PSTAT, 32'h60);
    chk(32'(irq_req), 32'h0);
    apb(1'b1, `PIC_OFF_PSTAT, 32'h40);
    chk(32'(irq_req), 32'h1);
    apb(1'b1, `PIC_OFF_CTRL2, 32'h0);
    chk(32'(irq_req), 32'h0);
    apb(1'b1, `PIC_OFF_CTRL2, 32'h8000);
    apb(1'b1, `PIC_OFF_IMASK, 32'h1);
    chk(32'(irq), 32'h1);
    apb(1'b1, `PIC_OFF_CTRL1, 32'h8000);
    apb(1'b1, `PIC_OFF_PSTAT, 32'hE0);
    rc(`PIC_OFF_PSTAT, 32'h40);
    apb(1'b1, `PIC_OFF_CTRL1, 32'h0);
    apb(1'b1, `PIC_OFF_FLAG, 32'h0);
    apb(1'b1, `PIC_OFF_ISTAT, 32'hF);
    chk(32'(irq), 32'h0);
    apb(1'b1, `PIC_OFF_CORE, 32'h8);
    rc(`PIC_OFF_CORE, 32'h0);
    apb(1'b1, 12'h03C, 32'hFFFFFFFF);
    chk(32'(err), 32'h1);
    chk(32'(pready), 32'h1);
    // Traps pre-empt a pending user request
    pulse(16'h0010);
    @(posedge pclk);
    dma <= 1'b1;
    lovf <= 1'b1;
    tev <= 8'h04;
    @(posedge pclk);
    dma <= 1'b0;
    lovf <= 1'b0;
    tev <= 8'h00;
    rc(`PIC_OFF_CTRL3, 32'h3);
    rc(`PIC_OFF_CTRL1, 32'h4);
    @(posedge pclk);
    en <= 1'b1;
    for (k = 0; k < 40 && ttk !== 1'b1; k++)
      @(posedge pclk);
    en <= 1'b0;
    rc(`PIC_OFF_CORE, 32'h8);
    apb(1'b1, `PIC_OFF_CTRL1, 32'h0);
    apb(1'b1, `PIC_OFF_CTRL3, 32'h0);
    apb(1'b1, `PIC_OFF_CTRL4, 32'h1);
    chk(32'(trap_req), 32'h1);
    rc(`PIC_OFF_CORE, 32'h0);
    chk(32'(irq_req), 32'h1);
    // External request zero through its pin
    apb(1'b1, `PIC_OFF_ENAB, 32'h1);
    apb(1'b1, `PIC_OFF_PRIO0, 32'h5);
    @(posedge pclk);
    pin <= 3'h1;
    for (k = 0; k < 10 && irq_req !== 1'b1; k++)
      @(negedge pclk);
    chk({19'h0, irq_req, vec, lvl}, 32'h1085);
    // Falling edge polarity on the same pin
    apb(1'b1, `PIC_OFF_FLAG, 32'h0);
    apb(1'b1, `PIC_OFF_CTRL2, 32'h8001);
    chk(32'(irq_req), 32'h0);
    @(posedge pclk);
    pin <= 3'h0;
    for (k = 0; k < 10 && irq_req !== 1'b1; k++)
      @(negedge pclk);
    chk({19'h0, irq_req, vec, lvl}, 32'h1085);
    // Reset in mid-run: state back to defaults, no false pin edge
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc(`PIC_OFF_FLAG, 32'h0);
    rc(`PIC_OFF_CTRL2, 32'h8000);
    chk(32'(irq_req), 32'h0);
    complete_run();
  end
endmodule
